// ===== tb_ulpi_phy_sync_interface.sv
// self-checking bench joining phy end and controller end
`timescale 1ns/1ps
`default_nettype none
module tb_ulpi_phy_sync_interface;
  logic       clk_i;
  logic       srst_i;
  logic       sel;
  logic [7:0] rxd;
  logic       rxv;
  logic       slp;
  logic [1:0] am;
  logic       req;
  logic       wr;
  logic [5:0] adr;
  logic [7:0] wd;
  logic       wake;
  logic       rtx;
  logic       txr;
  logic [7:0] txd;
  logic       txv;
  logic       txl;
  logic [7:0] tx_q [$];
  logic       cdrv;
  logic [1:0] mode;
  logic       se_en;
  logic [7:0] cfg0;
  logic       busy;
  logic       done;
  logic [7:0] rdat;
  logic [7:0] rxo;
  logic       rxo_v;
  logic [7:0] mem [64];
  logic [9:0] op_q [$];
  logic [7:0] rx_q [$];
  int         bad_count;
  int         checked;
  ulps_if ulpi();
  ulps_phy #(.PLL_CYC(4)) i_ulps_phy (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'h1),
    .clk_out_sel_i(sel), .ulpi(ulpi.phy), .rx_dat_i(rxd), .rx_vld_i(rxv), .tx_rdy_i(txr),
    .sleep_req_i(slp), .async_mode_i(am), .clk_drv_o(cdrv), .tx_dat_o(txd), .tx_vld_o(txv),
    .tx_last_o(txl), .mode_o(mode), .se_rx_en_o(se_en), .cfg0_o(cfg0));
  ulps_lnk i_ulps_lnk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'h1), .ulpi(ulpi.lnk),
    .req_i(req), .req_wr_i(wr), .req_tx_i(rtx), .req_addr_i(adr), .req_wdat_i(wd),
    .wake_i(wake),
    .busy_o(busy), .done_o(done), .rdat_o(rdat), .rx_dat_o(rxo), .rx_vld_o(rxo_v));
  ulps_properties #(.PLL_CYC(4)) i_ulps_properties (.clk_i(clk_i), .srst_i(srst_i),
    .dir(ulpi.dir), .nxt(ulpi.nxt), .stp(ulpi.stp), .phy_oe_n(ulpi.phy_oe_n),
    .lnk_oe_n(ulpi.lnk_oe_n), .bus(ulpi.bus));
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic cmp_dat(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_st(logic [1:0] got, logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // requests only after dir has been low two cycles
  task automatic wait_lo();
    int n;
    n = 0;
    for (int k = 0; k < 500 && n < 2; k++) begin
      tick();
      n = (ulpi.dir === 1'h0) ? n + 1 : 0;
    end
  endtask
  task automatic reg_op(logic w, logic [5:0] a, logic [7:0] d);
    wait_lo();
    req = 1'h1;
    wr = w;
    adr = a;
    wd = d;
    if (w) mem[a] = d;
    op_q.push_back({1'h0, !w, mem[a]});
    for (int k = 0; k < 20 && busy !== 1'h1; k++) tick();
    req = 1'h0;
    for (int k = 0; k < 50 && done !== 1'h1; k++) tick();
    cmp_st({1'h0, done}, 2'h1);
    tick();
  endtask
  task automatic sleep(logic [1:0] m);
    logic [1:0] e;
    e = (m == ulps_pkg::MODE_SYNC) ? ulps_pkg::MODE_LOWPWR : m;
    wait_lo();
    slp = 1'h1;
    am = m;
    for (int k = 0; k < 50 && mode !== e; k++) tick();
    tick();
    slp = 1'h0;
    cmp_st(mode, e);
    cmp_st({1'h0, se_en}, {1'h0, e != ulps_pkg::MODE_CARKIT});
    wake = 1'h1;
    for (int k = 0; k < 50 && mode !== ulps_pkg::MODE_SYNC; k++) tick();
    wake = 1'h0;
    cmp_st(mode, ulps_pkg::MODE_SYNC);
  endtask
  task automatic rx_byte(logic [7:0] b);
    wait_lo();
    rx_q.push_back(b);
    rxd = b;
    rxv = 1'h1;
    // phy raises dir on one edge and takes the byte on the next
    for (int k = 0; k < 50 && ulpi.dir !== 1'h1; k++) tick();
    tick();
    rxv = 1'h0;
    for (int k = 0; k < 50 && rxo_v !== 1'h1; k++) tick();
    cmp_st({1'h0, rxo_v}, 2'h1);
    tick(4);
  endtask
  // packet: command byte with pid, one data byte, throttled by tx_rdy
  task automatic tx_pkt(logic [5:0] a, logic [7:0] d);
    wait_lo();
    tx_q.push_back({ulps_pkg::CMD_TX, a});
    tx_q.push_back(d);
    op_q.push_back({2'h2, 8'h00});
    {req, rtx, adr, wd} = {2'h3, a, d};
    for (int k = 0; k < 20 && busy !== 1'h1; k++) begin
      txr = 1'($urandom());
      tick();
    end
    req = 1'h0;
    for (int k = 0; k < 50 && done !== 1'h1; k++) begin
      txr = 1'($urandom());
      tick();
    end
    {rtx, txr} = 2'h1;
    cmp_st({1'h0, done}, 2'h1);
    tick();
  endtask
  task automatic finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (done === 1'h1 && op_q.size() > 0) begin
      if (op_q[0][8]) cmp_dat(rdat, op_q[0][7:0]);
      if (op_q[0][9]) cmp_st({1'h0, txl}, 2'h1);
      void'(op_q.pop_front());
    end
    if (rxo_v === 1'h1 && rx_q.size() > 0) cmp_dat(rxo, rx_q.pop_front());
    else if (!srst_i && rxo_v !== 1'h0) cmp_st({1'h0, rxo_v}, 2'h0);
    if (txv === 1'h1 && tx_q.size() > 0) cmp_dat(txd, tx_q.pop_front());
    else if (!srst_i && txv !== 1'h0) cmp_st({1'h0, txv}, 2'h0);
  end
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    logic [5:0] a;
    logic [7:0] d;
    bad_count = 0;
    checked = 0;
    {srst_i, sel} = 2'h3;
    {rxd, rxv, slp, am, req, wr, adr, wd, wake} = 29'h0;
    {rtx, txr} = 2'h1;
    for (int i = 0; i < 64; i++) mem[i] = ulps_pkg::REG_RST;
    void'($urandom(68862));
    tick(8);
    srst_i = 1'h0;
    tick();
    cmp_st({1'h0, cdrv}, 2'h1);
    sel = 1'h0;
    for (int i = 0; i < 64; i++) reg_op(1'h0, i[5:0], 8'h00);
    cmp_st({1'h0, cdrv}, 2'h0);
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom());
      d = 8'($urandom());
      reg_op(1'h1, a, d);
      if (a == 6'h00) cmp_dat(cfg0, d);
      reg_op(1'h0, a, 8'h00);
    end
    for (int m = 0; m < 4; m++) sleep(m[1:0]);
    for (int i = 0; i < 64; i++) reg_op(1'h0, i[5:0], 8'h00);
    for (int i = 0; i < 4; i++) rx_byte(8'($urandom_range(255, 1)));
    for (int i = 0; i < 6; i++) tx_pkt({2'h0, 4'($urandom())}, 8'($urandom_range(255, 1)));
    finish_test();
  end
endmodule
`default_nettype wire

// ===== ulps_if.sv
// ulpi link wires joining phy end and controller end
`timescale 1ns/1ps
`default_nettype none
interface ulps_if;
  logic       dir;
  logic       nxt;
  logic       stp;
  logic [7:0] phy_dat;
  logic       phy_oe_n;
  logic [7:0] lnk_dat;
  logic       lnk_oe_n;
  logic [7:0] bus;
  assign bus = !phy_oe_n ? phy_dat : (!lnk_oe_n ? lnk_dat : 8'h00);
  modport phy (output dir, output nxt, input stp, output phy_dat, output phy_oe_n, input bus);
  modport lnk (input dir, input nxt, output stp, output lnk_dat, output lnk_oe_n, input bus);
endinterface
`default_nettype wire

// ===== ulps_lnk.sv
// controller end of the synchronous ulpi link
`timescale 1ns/1ps
`default_nettype none
module ulps_lnk (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  ulps_if.lnk             ulpi,
  input  wire logic       req_i,
  input  wire logic       req_wr_i,
  input  wire logic       req_tx_i,
  input  wire logic [5:0] req_addr_i,
  input  wire logic [7:0] req_wdat_i,
  input  wire logic       wake_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rdat_o,
  output logic [7:0]      rx_dat_o,
  output logic            rx_vld_o
);
  typedef enum logic [2:0] {
    ULPS_L_IDLE = 3'b000,
    ULPS_L_CMD  = 3'b001,
    ULPS_L_DAT  = 3'b010,
    ULPS_L_STP  = 3'b011,
    ULPS_L_RD   = 3'b100
  } ulps_lst_t;

  ulps_lst_t  st_r;
  logic [7:0] dout_r, wd_r;
  logic       oe_n_r, stp_r, wr_r, dir_q_r;

  assign ulpi.lnk_dat  = dout_r;
  // let go as soon as dir rises, waiting an edge would drive the turnaround
  assign ulpi.lnk_oe_n = oe_n_r || ulpi.dir;
  assign ulpi.stp      = stp_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r     <= ULPS_L_IDLE;
      dout_r   <= ulps_pkg::BUS_IDLE;
      wd_r     <= 8'h00;
      oe_n_r   <= 1'b1;
      stp_r    <= 1'b0;
      wr_r     <= 1'b0;
      dir_q_r  <= 1'b1;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      rdat_o   <= 8'h00;
      rx_dat_o <= 8'h00;
      rx_vld_o <= 1'b0;
    end else if (ce_i) begin
      dir_q_r  <= ulpi.dir;
      done_o   <= 1'b0;
      rx_vld_o <= 1'b0;
      // stp pulse used as wake request
      stp_r    <= wake_i && ulpi.dir && !stp_r;
      oe_n_r   <= ulpi.dir || dir_q_r;
      if (ulpi.dir && dir_q_r && ulpi.nxt) begin
        rx_dat_o <= ulpi.bus;
        rx_vld_o <= 1'b1;
      end
      unique case (st_r)
        ULPS_L_IDLE: begin
          dout_r <= ulps_pkg::BUS_IDLE;
          if (req_i && !ulpi.dir && !dir_q_r) begin
            if (req_tx_i) begin
              dout_r <= {ulps_pkg::CMD_TX, req_addr_i};
            end else begin
              dout_r <= {req_wr_i ? ulps_pkg::CMD_REGWR : ulps_pkg::CMD_REGRD, req_addr_i};
            end
            wd_r   <= req_wdat_i;
            // one data byte follows for a write or a packet
            wr_r   <= req_wr_i || req_tx_i;
            busy_o <= 1'b1;
            st_r   <= ULPS_L_CMD;
          end
        end
        ULPS_L_CMD: begin
          if (ulpi.dir) begin
            st_r <= ULPS_L_RD;
          end else if (ulpi.nxt && wr_r) begin
            dout_r <= wd_r;
            st_r   <= ULPS_L_DAT;
          end
        end
        ULPS_L_DAT: begin
          if (ulpi.nxt) begin
            // idle on bus with stp pulse
            dout_r <= ulps_pkg::BUS_IDLE;
            stp_r  <= 1'b1;
            st_r   <= ULPS_L_STP;
          end
        end
        ULPS_L_STP: begin
          stp_r  <= 1'b0;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          st_r   <= ULPS_L_IDLE;
        end
        ULPS_L_RD: begin
          if (ulpi.dir && dir_q_r) begin
            rdat_o <= ulpi.bus;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            st_r   <= ULPS_L_IDLE;
          end
        end
        default: st_r <= ULPS_L_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== ulps_phy.sv
// phy end of the synchronous ulpi link: arbiter, decoder and register array
`timescale 1ns/1ps
`default_nettype none
module ulps_phy #(
  parameter int PLL_CYC = ulps_pkg::PLL_START_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       clk_out_sel_i,
  ulps_if.phy             ulpi,
  input  wire logic [7:0] rx_dat_i,
  input  wire logic       rx_vld_i,
  input  wire logic       tx_rdy_i,
  input  wire logic       sleep_req_i,
  input  wire logic [1:0] async_mode_i,
  output logic            clk_drv_o,
  output logic [7:0]      tx_dat_o,
  output logic            tx_vld_o,
  output logic            tx_last_o,
  output logic [1:0]      mode_o,
  output logic            se_rx_en_o,
  output logic [7:0]      cfg0_o
);
  typedef enum logic [2:0] {
    ULPS_IDLE  = 3'b000,
    ULPS_CMD   = 3'b001,
    ULPS_WDAT  = 3'b010,
    ULPS_WSTP  = 3'b011,
    ULPS_RTA   = 3'b100,
    ULPS_RDAT  = 3'b101,
    ULPS_TX    = 3'b110,
    ULPS_SEND  = 3'b111
  } ulps_st_t;

  ulps_st_t   st_r;
  logic       dir_r, nxt_r, oe_n_r;
  logic       ta_now;
  logic [7:0] dout_r;
  logic [7:0] regs_r [ulps_pkg::NUM_REGS];
  logic [5:0] addr_r;
  logic [7:0] wdat_r;
  logic [15:0] pll_cnt_r;
  logic       pll_ok_r;
  logic [1:0] mode_r;
  logic       dir_q_r;

  function automatic logic [1:0] cmd_of(input logic [7:0] b);
    return b[ulps_pkg::CMD_MSB:ulps_pkg::CMD_LSB];
  endfunction

  assign ulpi.dir      = dir_r;
  assign ulpi.nxt      = nxt_r;
  assign ulpi.phy_dat  = dout_r;
  // drive only when owning the bus
  assign ulpi.phy_oe_n = oe_n_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pll_cnt_r <= 16'h0000;
      pll_ok_r  <= 1'b0;
    end else if (ce_i && !pll_ok_r) begin
      pll_cnt_r <= pll_cnt_r + 16'h0001;
      pll_ok_r  <= (pll_cnt_r == 16'(PLL_CYC - 1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_r <= ulps_pkg::MODE_SYNC;
    end else if (ce_i) begin
      if (mode_r != ulps_pkg::MODE_SYNC && ulpi.stp) begin
        mode_r <= ulps_pkg::MODE_SYNC;
      end else if (mode_r == ulps_pkg::MODE_SYNC && st_r == ULPS_IDLE && sleep_req_i) begin
        mode_r <= (async_mode_i == ulps_pkg::MODE_SYNC) ? ulps_pkg::MODE_LOWPWR : async_mode_i;
      end
    end
  end

  // dir as it was one edge ago
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dir_q_r <= 1'b1;
    end else if (ce_i) begin
      dir_q_r <= dir_r;
    end
  end

  // dir moved on the last edge: bus undriven now; a registered flag would lag a cycle
  assign ta_now = (dir_q_r != dir_r);

  // single decoder, routes to tx or registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r      <= ULPS_IDLE;
      dir_r     <= 1'b1;
      nxt_r     <= 1'b0;
      oe_n_r    <= 1'b1;
      dout_r    <= ulps_pkg::BUS_IDLE;
      addr_r    <= 6'h00;
      wdat_r    <= 8'h00;
      tx_dat_o  <= 8'h00;
      tx_vld_o  <= 1'b0;
      tx_last_o <= 1'b0;
    end else if (ce_i) begin
      tx_vld_o  <= 1'b0;
      tx_last_o <= 1'b0;
      unique case (st_r)
        ULPS_IDLE: begin
          oe_n_r <= 1'b1;
          // hold dir while pll or async mode
          if (!pll_ok_r || mode_r != ulps_pkg::MODE_SYNC) begin
            dir_r <= 1'b1;
          // take bus when receive data waits
          end else if (rx_vld_i && !dir_r) begin
            dir_r <= 1'b1;
            st_r  <= ULPS_SEND;
          end else begin
            dir_r <= 1'b0;
            if (!dir_r && !ta_now && ulpi.bus != ulps_pkg::BUS_IDLE) begin
              addr_r <= ulpi.bus[ulps_pkg::ADDR_W-1:0];
              unique case (cmd_of(ulpi.bus))
                ulps_pkg::CMD_TX:    st_r <= ULPS_TX;
                ulps_pkg::CMD_REGWR: st_r <= ULPS_CMD;
                ulps_pkg::CMD_REGRD: st_r <= ULPS_CMD;
                default:             st_r <= ULPS_IDLE;
              endcase
              nxt_r <= 1'b1;
            end
          end
        end
        ULPS_CMD: begin
          nxt_r <= 1'b0;
          if (cmd_of(ulpi.bus) == ulps_pkg::CMD_REGRD) begin
            dir_r <= 1'b1;
            st_r  <= ULPS_RTA;
          end else begin
            nxt_r <= 1'b1;
            st_r  <= ULPS_WDAT;
          end
        end
        ULPS_WDAT: begin
          wdat_r <= ulpi.bus;
          nxt_r  <= 1'b0;
          st_r   <= ULPS_WSTP;
        end
        ULPS_WSTP: begin
          if (ulpi.stp) begin
            st_r <= ULPS_IDLE;
          end
        end
        ULPS_RTA: begin
          oe_n_r <= 1'b0;
          dout_r <= regs_r[addr_r];
          st_r   <= ULPS_RDAT;
        end
        ULPS_RDAT: begin
          oe_n_r <= 1'b1;
          dir_r  <= 1'b0;
          st_r   <= ULPS_IDLE;
        end
        ULPS_TX: begin
          nxt_r <= tx_rdy_i && !ulpi.stp;
          if (nxt_r && !ulpi.stp) begin
            tx_dat_o <= ulpi.bus;
            tx_vld_o <= 1'b1;
          end
          // stp ends stream, prior byte last
          if (ulpi.stp) begin
            tx_last_o <= 1'b1;
            st_r      <= ULPS_IDLE;
          end
        end
        ULPS_SEND: begin
          // one cycle per byte, no extra latency
          oe_n_r <= 1'b0;
          nxt_r  <= rx_vld_i;
          dout_r <= rx_dat_i;
          if (!rx_vld_i && !ta_now) begin
            oe_n_r <= 1'b1;
            nxt_r  <= 1'b0;
            dir_r  <= 1'b0;
            st_r   <= ULPS_IDLE;
          end
        end
      endcase
    end
  end

  // register array; no clear on mode change
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < ulps_pkg::NUM_REGS; i++) begin
        regs_r[i] <= ulps_pkg::REG_RST;
      end
    end else if (ce_i && st_r == ULPS_WSTP && ulpi.stp) begin
      regs_r[addr_r] <= wdat_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clk_drv_o  <= 1'b0;
      mode_o     <= ulps_pkg::MODE_SYNC;
      se_rx_en_o <= 1'b1;
      cfg0_o     <= ulps_pkg::REG_RST;
    end else if (ce_i) begin
      clk_drv_o  <= clk_out_sel_i;
      mode_o     <= mode_r;
      se_rx_en_o <= (mode_r != ulps_pkg::MODE_CARKIT);
      cfg0_o     <= regs_r[0];
    end
  end
endmodule
`default_nettype wire

// ===== ulps_pkg.sv
// shared constants for the synchronous ulpi link between phy and controller
package ulps_pkg;
  localparam int          DATA_W        = 8;
  localparam int          CMD_MSB       = 7;
  localparam int          CMD_LSB       = 6;
  localparam int          ADDR_W        = 6;
  localparam logic [1:0]  CMD_IDLE      = 2'h0;
  localparam logic [1:0]  CMD_TX        = 2'h1;
  localparam logic [1:0]  CMD_REGWR     = 2'h2;
  localparam logic [1:0]  CMD_REGRD     = 2'h3;
  localparam logic [7:0]  BUS_IDLE      = 8'h00;
  localparam int          NUM_REGS      = 64;
  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam int          CLK_MHZ       = 60;
  localparam int          RX_END_DLY    = 43;
  localparam int          RX_END_DLY_MAX = 63;
  localparam int          PLL_START_CYC = 16;
  localparam logic [1:0]  MODE_SYNC     = 2'h0;
  localparam logic [1:0]  MODE_LOWPWR   = 2'h1;
  localparam logic [1:0]  MODE_SERIAL   = 2'h2;
  localparam logic [1:0]  MODE_CARKIT   = 2'h3;
endpackage

// ===== ulps_properties.sv
// wire-level checks of the ulpi link between the two ends
`timescale 1ns/1ps
`default_nettype none
module ulps_properties #(
  parameter int PLL_CYC = 4
) (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       dir,
  input wire logic       nxt,
  input wire logic       stp,
  input wire logic       phy_oe_n,
  input wire logic       lnk_oe_n,
  input wire logic [7:0] bus
);
  logic [7:0] up_r;
  // cycles since reset, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    if (srst_i) up_r <= 8'h00;
    else if (up_r != 8'hff) up_r <= up_r + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // idle byte before a command, so data bytes never look like one
  sequence s_wr; !dir && !$past(dir) && $past(bus) == 8'h00 && bus[7:6] == 2'h2; endsequence
  sequence s_rd; !dir && !$past(dir) && $past(bus) == 8'h00 && bus[7:6] == 2'h3; endsequence
  property p_phy_own; !phy_oe_n |-> dir && $past(dir); endproperty
  a_phy_own: assert property (p_phy_own) else $error("phy drive");
  property p_lnk_own; dir && $past(dir) |-> lnk_oe_n; endproperty
  a_lnk_own: assert property (p_lnk_own) else $error("link drive");
  property p_lnk_turn; !lnk_oe_n |-> !dir && !$past(dir); endproperty
  a_lnk_turn: assert property (p_lnk_turn) else $error("no turnaround");
  property p_stp; stp |=> !stp; endproperty
  a_stp: assert property (p_stp) else $error("stop too long");
  property p_pll; up_r < PLL_CYC |-> dir; endproperty
  a_pll: assert property (p_pll) else $error("dir low in startup");
  property p_wr; s_wr |=> nxt ##1 nxt ##1 (!nxt && stp && bus == 8'h00) ##1 !stp; endproperty
  a_wr: assert property (p_wr) else $error("write sequence");
  property p_rd; s_rd |=> nxt ##1 (dir && !nxt) ##1 (dir && !phy_oe_n) ##1 !dir; endproperty
  a_rd: assert property (p_rd) else $error("read sequence");
  property p_nxt; $rose(nxt) && !dir |-> $past(bus) != 8'h00 && !$past(dir, 2); endproperty
  a_nxt: assert property (p_nxt) else $error("nxt without command");
  property p_tx_end; stp && !dir |=> !nxt; endproperty
  a_tx_end: assert property (p_tx_end) else $error("nxt after stop");
  c_wr: cover property (s_wr);
  c_tx: cover property (!dir && nxt && bus[7:6] == 2'h1);
  c_rd: cover property (s_rd);
  c_dir: cover property ($fell(dir));
endmodule
`default_nettype wire
